// *** hw/flash_cmd_pkg.sv ***
// flash_cmd_pkg: opcodes, sizes, timing counts and carrier types of the
// security area, block lock and software reset command logic.
// assumes a 20 MHz core clock that samples the serial link pins.
package flash_cmd_pkg;
    // core clock and derived timing
    localparam int CLK_FREQ_MHZ = 20;
    localparam int RESET_TIME_US = 30;
    localparam int RESET_CYCLES = RESET_TIME_US * CLK_FREQ_MHZ;
    localparam int TIMER_W = 24;
    // opcodes
    localparam logic [7:0] CMD_SEC_ERASE = 8'h44;
    localparam logic [7:0] CMD_SEC_PROG = 8'h42;
    localparam logic [7:0] CMD_SEC_READ = 8'h48;
    localparam logic [7:0] CMD_LOCK = 8'h36;
    localparam logic [7:0] CMD_UNLOCK = 8'h39;
    localparam logic [7:0] CMD_LOCK_READ = 8'h3D;
    localparam logic [7:0] CMD_GLOBAL_LOCK = 8'h7E;
    localparam logic [7:0] CMD_GLOBAL_UNLOCK = 8'h98;
    localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
    localparam logic [7:0] CMD_RESET = 8'h99;
    // security area layout
    localparam int SEC_ADDR_W = 12;
    localparam int SEC_BYTES = 4096;
    localparam int SEC_PAGES = 16;
    localparam int PAGE_BYTE_W = 8;
    localparam logic [SEC_ADDR_W-1:0] SEC_LAST = 12'hFFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // block/sector lock granule
    localparam int LOCK_IDX_LSB = 21;
    localparam int LOCK_IDX_W = 6;
    localparam int LOCK_COUNT = 64;
    // field lengths in bits and bits per clock
    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam logic [5:0] ADDR3_BITS = 6'h18;
    localparam logic [5:0] ADDR4_BITS = 6'h20;
    localparam logic [5:0] STEP_SINGLE = 6'h01;
    localparam logic [5:0] STEP_QUAD = 6'h04;
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_QUAD = 4'hF;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] io;
    } link_pins_type;

    localparam link_pins_type LINK_IDLE = 6'h20;

    typedef struct packed {
        logic en;
        logic [SEC_ADDR_W-1:0] addr;
        logic [7:0] data;
    } mem_write_type;

    typedef enum logic [2:0] {F_IDLE, F_CMD, F_ADDR, F_DUMMY, F_DATA, F_OUT, F_END, F_SKIP} frame_state_type;
    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROG, OP_RESET} op_state_type;
endpackage

// *** hw/link_pin_sync.sv ***
// link_pin_sync: brings chip select, serial clock and data lines into the
// core clock domain and reports chip select and serial clock edges.
// assumes the pins are asynchronous and slow against the core clock.
`timescale 1ns/100ps
`default_nettype none
module link_pin_sync import flash_cmd_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw pins
    input wire link_pins_type pins_in,
    // filtered pins and edges, one cycle pulses
    output link_pins_type pins,
    output logic sclk_rise,
    output logic sclk_fall,
    output logic cs_fall,
    output logic cs_rise
);
    link_pins_type s1_q, s2_q, s3_q, filt_q, filt_d;
    logic sclk_rise_d, sclk_fall_d, cs_fall_d, cs_rise_d;

    // a change counts once the second and third stage agree
    for (genvar g = 0; g < $bits(link_pins_type); g++) begin : g_bit
        always_comb begin
            filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
        end
    end

    always_comb begin
        sclk_rise_d = filt_d.sclk & ~filt_q.sclk;
        sclk_fall_d = ~filt_d.sclk & filt_q.sclk;
        cs_fall_d = ~filt_d.cs_n & filt_q.cs_n;
        cs_rise_d = filt_d.cs_n & ~filt_q.cs_n;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= LINK_IDLE;
            s2_q <= LINK_IDLE;
            s3_q <= LINK_IDLE;
            filt_q <= LINK_IDLE;
            sclk_rise <= 1'b0;
            sclk_fall <= 1'b0;
            cs_fall <= 1'b0;
            cs_rise <= 1'b0;
        end else begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
            sclk_rise <= sclk_rise_d;
            sclk_fall <= sclk_fall_d;
            cs_fall <= cs_fall_d;
            cs_rise <= cs_rise_d;
        end
    end

    assign pins = filt_q;
endmodule
`default_nettype wire

// *** hw/sec_area_mem.sv ***
// sec_area_mem: byte array of the security storage area, one write port and
// one read port with registered read data.
// assumes the caller never writes and reads the same byte in one cycle.
`timescale 1ns/100ps
`default_nettype none
module sec_area_mem import flash_cmd_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write port
    input wire mem_write_type wr,
    // read port
    input wire logic [SEC_ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data
);
    // sixteen pages of 256 bytes
    logic [7:0] mem_q [SEC_BYTES];

    always_ff @(posedge clk) begin
        if (wr.en) begin
            mem_q[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule
`default_nettype wire

// *** hw/otp_area_lock_and_reset_cmds.sv ***
// otp_area_lock_and_reset_cmds: serial flash command logic for the security
// area (erase, program, read), block/sector locks and the software reset.
// assumes the write latch, suspend, power-down and mode flags are kept by
// neighbouring logic on the same clock; link pins arrive asynchronously.
//
// Notes on behaviour
// - a separate 4 KB security area of sixteen pages, erased and programmed alone
// - security erase 44h needs the write latch set beforehand
// - security erase runs only if the frame ends right after the last address byte
// - frame end starts a timed erase; busy reads 1 until it ends
// - write latch is cleared during every security erase or program cycle
// - with the security lock bit set, erase and program are ignored
// - program/read address: page in bits 11-8, byte in 7-0, upper bits zero; only program checks this, read ignores the upper bits
// - addresses are 24 bits, or 32 bits in four-byte address mode
// - program 42h takes address and at least one byte; timed cycle holds busy
// - read 48h takes address and dummy byte, data leaves on falling clock
// - read address increments per byte, wrapping FFF to 000 until frame end
// - per-block locks protect only while the protection scheme bit is 0
// - lock 36h sets, unlock 39h clears the addressed block lock bit
// - lock read 3Dh returns the addressed lock bit in the lowest position
// - global lock 7Eh sets all lock bits, global unlock 98h clears all
// - reset needs 66h then 99h in separate frames, in either line mode
// - accepted reset aborts operations and clears volatile state; the lock bits here keep their values
// - after reset the device refuses every command for the reset time
// - program suspend blocks erase and program; erase suspend blocks erase
// - in deep power-down only the reset pair is taken and it wakes the device
`timescale 1ns/100ps
`default_nettype none
module otp_area_lock_and_reset_cmds import flash_cmd_pkg::*; #(
    parameter int SECTOR_ERASE_TIME_US = 50000,
    parameter int PAGE_PROGRAM_TIME_US = 500
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    // device flags kept elsewhere
    input wire logic write_latch_flag,
    input wire logic four_line_command_mode,
    input wire logic four_byte_mode,
    input wire logic protect_scheme_select,
    input wire logic security_lock,
    input wire logic [1:0] suspend_flags,
    input wire logic deep_power_down,
    // flag updates towards the rest of the device
    output logic busy_flag,
    output logic write_latch_clear,
    output logic soft_reset,
    output logic reset_in_progress,
    // lock lookup for array writes
    input wire logic [31:0] query_addr,
    output logic query_locked
);
    localparam int ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_FREQ_MHZ;
    localparam int PROG_CYCLES = PAGE_PROGRAM_TIME_US * CLK_FREQ_MHZ;

    link_pins_type pins_raw, pins;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    logic [7:0] mem_rdata;
    mem_write_type prog_wr, mem_wr;

    // frame group
    frame_state_type fstate_q, fstate_d;
    logic [5:0] cnt_q, cnt_d;
    logic [31:0] in_sr_q, in_sr_d;
    logic [7:0] opcode_q, opcode_d;
    logic [31:0] addr_q, addr_d;
    logic quad_q, quad_d;
    logic addr4_q, addr4_d;
    logic got_data_q, got_data_d;
    logic prog_ok_q, prog_ok_d;
    logic [SEC_ADDR_W-1:0] rd_addr_q, rd_addr_d;
    logic [2:0] ocnt_q, ocnt_d;
    logic [7:0] out_sr_q, out_sr_d;
    logic oe_q, oe_d;
    logic [3:0] io_out_q, io_out_d;
    logic [3:0] io_oe_q, io_oe_d;
    logic [5:0] step, next_cnt, field_len;
    logic [31:0] new_sr, new_addr;

    // operation group
    op_state_type op_q, op_d;
    logic [TIMER_W-1:0] timer_q, timer_d;
    logic [SEC_ADDR_W-1:0] sweep_q, sweep_d;
    logic sweep_done_q, sweep_done_d;
    logic rst_enable_q, rst_enable_d;
    logic wl_clear_q, wl_clear_d;
    logic soft_reset_q, soft_reset_d;
    mem_write_type erase_wr;

    // lock group
    logic [LOCK_COUNT-1:0] lock_q, lock_d;
    logic lock_cmd, unlock_cmd, glock_cmd, gunlock_cmd;
    logic [LOCK_IDX_W-1:0] lock_idx;

    // frame end decode
    logic frame_ok, at_end, busy;
    logic erase_go, prog_go, enable_go, reset_go, write_cmds_ok;

    assign pins_raw = '{cs_n: cs_n, sclk: sclk, io: io_in};

    link_pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pins_in(pins_raw),
        .pins(pins),
        .sclk_rise(sclk_rise),
        .sclk_fall(sclk_fall),
        .cs_fall(cs_fall),
        .cs_rise(cs_rise)
    );

    sec_area_mem u_mem (
        .clk(clk),
        .rst(rst),
        .wr(mem_wr),
        .rd_addr(rd_addr_q),
        .rd_data(mem_rdata)
    );

    // shifting, most significant bit first
    always_comb begin
        step = quad_q ? STEP_QUAD : STEP_SINGLE;
        next_cnt = cnt_q + step;
        new_sr = quad_q ? {in_sr_q[27:0], pins.io} : {in_sr_q[30:0], pins.io[0]};
        new_addr = addr4_q ? new_sr : {8'h00, new_sr[23:0]};
        case (fstate_q)
            F_CMD: field_len = CMD_BITS;
            F_ADDR: field_len = addr4_q ? ADDR4_BITS : ADDR3_BITS;
            default: field_len = CMD_BITS;
        endcase
    end

    always_comb begin
        fstate_d = fstate_q;
        cnt_d = cnt_q;
        in_sr_d = in_sr_q;
        opcode_d = opcode_q;
        addr_d = addr_q;
        quad_d = quad_q;
        addr4_d = addr4_q;
        got_data_d = got_data_q;
        prog_ok_d = prog_ok_q;
        rd_addr_d = rd_addr_q;
        ocnt_d = ocnt_q;
        out_sr_d = out_sr_q;
        oe_d = oe_q;
        prog_wr = '0;
        if (cs_fall) begin
            fstate_d = reset_in_progress ? F_SKIP : F_CMD;
            cnt_d = 6'h00;
            quad_d = four_line_command_mode;
            addr4_d = four_byte_mode;
            got_data_d = 1'b0;
            prog_ok_d = 1'b0;
            ocnt_d = 3'h0;
            oe_d = 1'b0;
        end else if (cs_rise) begin
            fstate_d = F_IDLE;
            oe_d = 1'b0;
        end else if (!pins.cs_n && sclk_rise && fstate_q != F_OUT && fstate_q != F_IDLE) begin
            in_sr_d = new_sr;
            cnt_d = next_cnt;
            if (next_cnt == field_len) begin
                cnt_d = 6'h00;
                case (fstate_q)
                    F_CMD: begin
                        opcode_d = new_sr[7:0];
                        case (new_sr[7:0])
                            CMD_SEC_ERASE, CMD_SEC_PROG, CMD_SEC_READ,
                            CMD_LOCK, CMD_UNLOCK, CMD_LOCK_READ: fstate_d = deep_power_down ? F_SKIP : F_ADDR;
                            CMD_GLOBAL_LOCK, CMD_GLOBAL_UNLOCK,
                            CMD_RESET_ENABLE, CMD_RESET: fstate_d = F_END;
                            default: fstate_d = F_SKIP;
                        endcase
                    end
                    F_ADDR: begin
                        addr_d = new_addr;
                        // program rights are settled before any byte reaches the array
                        prog_ok_d = write_latch_flag && !security_lock && !suspend_flags[0]
                            && !busy && !deep_power_down && !reset_in_progress
                            && new_addr[31:SEC_ADDR_W] == '0;
                        case (opcode_q)
                            CMD_SEC_READ: fstate_d = F_DUMMY;
                            CMD_SEC_PROG: fstate_d = F_DATA;
                            CMD_LOCK_READ: fstate_d = F_OUT;
                            default: fstate_d = F_END;
                        endcase
                    end
                    F_DUMMY: begin
                        fstate_d = F_OUT;
                        rd_addr_d = addr_q[SEC_ADDR_W-1:0];
                    end
                    F_DATA: begin
                        // byte address wraps inside the page
                        prog_wr = '{en: prog_ok_q, addr: addr_q[SEC_ADDR_W-1:0], data: new_sr[7:0]};
                        addr_d[PAGE_BYTE_W-1:0] = addr_q[PAGE_BYTE_W-1:0] + 8'h01;
                        got_data_d = 1'b1;
                    end
                    F_END: fstate_d = F_SKIP;
                    default: fstate_d = fstate_q;
                endcase
            end
        end else if (!pins.cs_n && sclk_fall && fstate_q == F_OUT) begin
            oe_d = 1'b1;
            if (ocnt_q == 3'h0) begin
                if (opcode_q == CMD_SEC_READ) begin
                    out_sr_d = mem_rdata;
                    rd_addr_d = rd_addr_q + 12'h001;
                end else begin
                    out_sr_d = {7'h00, lock_q[lock_idx]};
                end
            end else begin
                out_sr_d = quad_q ? {out_sr_q[3:0], 4'h0} : {out_sr_q[6:0], 1'b0};
            end
            ocnt_d = ocnt_q + step[2:0];
        end
    end

    always_comb begin
        io_out_d = quad_q ? out_sr_d[7:4] : {2'b00, out_sr_d[7], 1'b0};
        io_oe_d = oe_d ? (quad_q ? OE_QUAD : OE_SINGLE) : 4'h0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fstate_q <= F_IDLE;
            cnt_q <= 6'h00;
            in_sr_q <= 32'h0000_0000;
            opcode_q <= 8'h00;
            addr_q <= 32'h0000_0000;
            quad_q <= 1'b0;
            addr4_q <= 1'b0;
            got_data_q <= 1'b0;
            prog_ok_q <= 1'b0;
            rd_addr_q <= 12'h000;
            ocnt_q <= 3'h0;
            out_sr_q <= 8'h00;
            oe_q <= 1'b0;
            io_out_q <= 4'h0;
            io_oe_q <= 4'h0;
        end else begin
            fstate_q <= fstate_d;
            cnt_q <= cnt_d;
            in_sr_q <= in_sr_d;
            opcode_q <= opcode_d;
            addr_q <= addr_d;
            quad_q <= quad_d;
            addr4_q <= addr4_d;
            got_data_q <= got_data_d;
            prog_ok_q <= prog_ok_d;
            rd_addr_q <= rd_addr_d;
            ocnt_q <= ocnt_d;
            out_sr_q <= out_sr_d;
            oe_q <= oe_d;
            io_out_q <= io_out_d;
            io_oe_q <= io_oe_d;
        end
    end

    // decode of a finished frame: whole fields only, nothing past the last one
    always_comb begin
        busy = op_q == OP_ERASE || op_q == OP_PROG;
        frame_ok = cs_rise && cnt_q == 6'h00 && op_q != OP_RESET;
        at_end = frame_ok && fstate_q == F_END;
        write_cmds_ok = !busy && !deep_power_down;
        enable_go = at_end && opcode_q == CMD_RESET_ENABLE;
        reset_go = at_end && opcode_q == CMD_RESET && rst_enable_q;
        erase_go = at_end && opcode_q == CMD_SEC_ERASE && write_latch_flag && !security_lock
            && suspend_flags == 2'b00 && write_cmds_ok;
        prog_go = frame_ok && fstate_q == F_DATA && got_data_q && prog_ok_q;
        lock_cmd = at_end && opcode_q == CMD_LOCK && write_cmds_ok;
        unlock_cmd = at_end && opcode_q == CMD_UNLOCK && write_cmds_ok;
        glock_cmd = at_end && opcode_q == CMD_GLOBAL_LOCK && write_cmds_ok;
        gunlock_cmd = at_end && opcode_q == CMD_GLOBAL_UNLOCK && write_cmds_ok;
        lock_idx = addr_q[LOCK_IDX_LSB +: LOCK_IDX_W];
    end

    always_comb begin
        op_d = op_q;
        timer_d = timer_q;
        sweep_d = sweep_q;
        sweep_done_d = sweep_done_q;
        rst_enable_d = rst_enable_q;
        wl_clear_d = 1'b0;
        soft_reset_d = 1'b0;
        erase_wr = '0;
        // any other completed frame disarms the reset
        if (cs_rise) begin
            rst_enable_d = enable_go;
        end
        case (op_q)
            OP_IDLE: op_d = OP_IDLE;
            OP_ERASE: begin
                // the array is swept to the erased value while the timer runs
                erase_wr = '{en: !sweep_done_q, addr: sweep_q, data: ERASED_BYTE};
                sweep_d = sweep_q + 12'h001;
                if (sweep_q == SEC_LAST) begin
                    sweep_done_d = 1'b1;
                end
                timer_d = timer_q - 1'b1;
                if (timer_q == '0 && sweep_done_q) begin
                    op_d = OP_IDLE;
                end
            end
            OP_PROG, OP_RESET: begin
                timer_d = timer_q - 1'b1;
                if (timer_q == '0) begin
                    op_d = OP_IDLE;
                end
            end
            default: op_d = OP_IDLE;
        endcase
        if (reset_go) begin
            // aborts any cycle under way; neighbours clear their volatile state
            op_d = OP_RESET;
            timer_d = TIMER_W'(RESET_CYCLES - 1);
            soft_reset_d = 1'b1;
            rst_enable_d = 1'b0;
        end else if (erase_go) begin
            op_d = OP_ERASE;
            timer_d = TIMER_W'(ERASE_CYCLES - 1);
            sweep_d = 12'h000;
            sweep_done_d = 1'b0;
            wl_clear_d = 1'b1;
        end else if (prog_go) begin
            op_d = OP_PROG;
            timer_d = TIMER_W'(PROG_CYCLES - 1);
            wl_clear_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_q <= OP_IDLE;
            timer_q <= '0;
            sweep_q <= 12'h000;
            sweep_done_q <= 1'b1;
            rst_enable_q <= 1'b0;
            wl_clear_q <= 1'b0;
            soft_reset_q <= 1'b0;
        end else begin
            op_q <= op_d;
            timer_q <= timer_d;
            sweep_q <= sweep_d;
            sweep_done_q <= sweep_done_d;
            rst_enable_q <= rst_enable_d;
            wl_clear_q <= wl_clear_d;
            soft_reset_q <= soft_reset_d;
        end
    end

    // one lock bit per granule
    for (genvar g = 0; g < LOCK_COUNT; g++) begin : g_lock
        always_comb begin
            if (glock_cmd) begin
                lock_d[g] = 1'b1;
            end else if (gunlock_cmd) begin
                lock_d[g] = 1'b0;
            end else if ((lock_cmd || unlock_cmd) && lock_idx == LOCK_IDX_W'(g)) begin
                lock_d[g] = lock_cmd;
            end else begin
                lock_d[g] = lock_q[g];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lock_q <= '0;
        end else begin
            lock_q <= lock_d;
        end
    end

    assign mem_wr = (op_q == OP_ERASE) ? erase_wr : prog_wr;
    assign busy_flag = busy;
    assign write_latch_clear = wl_clear_q;
    assign soft_reset = soft_reset_q;
    assign reset_in_progress = op_q == OP_RESET;
    // with the scheme bit set, block protect in status decides instead
    assign query_locked = !protect_scheme_select && lock_q[query_addr[LOCK_IDX_LSB +: LOCK_IDX_W]];
    assign io_out = io_out_q;
    assign io_oe = io_oe_q;
endmodule
`default_nettype wire

// *** dv/otp_cmds_checker.sv ***
// otp_cmds_checker: timing relations at the command block's ports.
// assumes bench-held flag inputs stay stable across each frame end.
`timescale 1ns/100ps
`default_nettype none
module otp_cmds_checker import flash_cmd_pkg::*; (
    // watched ports
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic [3:0] io_oe,
    input wire logic write_latch_flag,
    input wire logic security_lock,
    input wire logic [1:0] suspend_flags,
    input wire logic deep_power_down,
    input wire logic protect_scheme_select,
    input wire logic busy_flag,
    input wire logic write_latch_clear,
    input wire logic soft_reset,
    input wire logic reset_in_progress,
    input wire logic query_locked
);
    // cycles spent in the reset interval so far
    logic [9:0] rip_cnt_q;
    always_ff @(posedge clk) begin
        rip_cnt_q <= reset_in_progress ? rip_cnt_q + 10'h001 : 10'h000;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_busy_start: assert property ($rose(busy_flag) |-> cs_n && write_latch_flag)
        else $error("busy rose mid frame or without latch");
    a_latch_clear: assert property ($rose(busy_flag) |-> write_latch_clear || $past(write_latch_clear))
        else $error("no latch clear at cycle start");
    a_lock_scheme: assert property (query_locked |-> !protect_scheme_select)
        else $error("lock applied under block protect scheme");
    a_reset_abort: assert property (soft_reset |=> !busy_flag && reset_in_progress)
        else $error("reset did not abort cycle");
    a_reset_hold: assert property ($fell(reset_in_progress) |-> rip_cnt_q == 10'(RESET_CYCLES))
        else $error("reset interval of wrong length");
    a_refuse_all: assert property (reset_in_progress || deep_power_down |-> !$rose(busy_flag))
        else $error("cycle started while refusing");
    a_suspend_lock: assert property ($rose(busy_flag) |-> !suspend_flags[0] && !security_lock)
        else $error("cycle started while suspended or locked");
    a_oe_release: assert property (cs_n [*8] |-> io_oe == 4'h0)
        else $error("output still driven after frame");
    c_busy: cover property ($rose(busy_flag));
    c_reset: cover property (soft_reset);
    c_read: cover property (io_oe == 4'h2);
endmodule
bind otp_area_lock_and_reset_cmds otp_cmds_checker chk (.clk, .rst, .cs_n, .io_oe, .write_latch_flag,
    .security_lock, .suspend_flags, .deep_power_down, .protect_scheme_select, .busy_flag,
    .write_latch_clear, .soft_reset, .reset_in_progress, .query_locked);
`default_nettype wire

// *** dv/flash_host_model.sv ***
// flash_host_model: host controller that frames commands on the link pins.
// assumes a 400 ns serial clock that stands low outside frames.
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
    // link pins
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io,
    // data line back from the device
    input wire logic miso
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io = 4'hF;
    end
    // tx left aligned, nc clocks out, then nr bits read back
    task automatic frame(input logic [63:0] tx, input int nc, input logic quad, input int nr,
                         output logic [15:0] rx);
        rx = 16'h0;
        cs_n = 1'b0;
        for (int i = 0; i < nc; i++) begin
            #100 io = quad ? tx[63:60] : {~io[3:1], tx[63]};
            tx = quad ? tx << 4 : tx << 1;
            #100 sclk = 1'b1;
            #200 sclk = 1'b0;
        end
        for (int i = 0; i < nr; i++) begin
            #200 sclk = 1'b1;
            #190 rx = {rx[14:0], miso};
            #10 sclk = 1'b0;
        end
        #200 cs_n = 1'b1;
        io = ~io;
        #400;
    endtask
endmodule
`default_nettype wire

// *** dv/otp_area_lock_and_reset_cmds_tb_top.sv ***
// testbench: security area, block lock and reset commands through the link.
// assumes the host model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module otp_area_lock_and_reset_cmds_tb_top;
    logic clk = 1'b0, rst = 1'b1, wl = 1'b1, fl = 1'b0, fb = 1'b0, pss = 1'b0, sl = 1'b0, dpd = 1'b0;
    logic [1:0] sus = 2'h0;
    logic [31:0] qa = 32'h0;
    logic [3:0] io_out, io_oe, hio, io_w;
    logic cs_n, sclk, busy, srst, rip, qlk;
    logic [15:0] rx;
    logic [11:0] a;
    logic [7:0] mem [4096];
    logic [4:0] bad [6] = '{5'h00, 5'h18, 5'h12, 5'h14, 5'h11, 5'h10};
    int failures = 0, tests_run = 0, cyc = 0, seed = 44095;
    always #25 clk = ~clk;
    assign io_w = (io_oe & io_out) | (~io_oe & hio);
    otp_area_lock_and_reset_cmds #(.SECTOR_ERASE_TIME_US(210), .PAGE_PROGRAM_TIME_US(2)) dut (.clk(clk),
        .rst(rst), .cs_n(cs_n), .sclk(sclk), .io_in(io_w), .io_out(io_out), .io_oe(io_oe),
        .write_latch_flag(wl), .four_line_command_mode(fl), .four_byte_mode(fb),
        .protect_scheme_select(pss), .security_lock(sl), .suspend_flags(sus), .deep_power_down(dpd),
        .busy_flag(busy), .write_latch_clear(), .soft_reset(srst), .reset_in_progress(rip),
        .query_addr(qa), .query_locked(qlk));
    flash_host_model host (.cs_n(cs_n), .sclk(sclk), .io(hio), .miso(io_w[1]));
    function automatic logic [15:0] exp16(input logic [11:0] x);
        return {mem[x], mem[x + 12'h001]};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 6000 && busy !== 1'b0; i++) @(posedge clk);
        @(posedge clk) #1 check(busy, 1'b0);
    endtask
    task automatic finish_test;
        $display("%0d checks, %0d failures", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            finish_test;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            a = k < 2 ? 12'hFFF * k[0] : $random(seed);
            mem[a] = $random(seed);
            #1 fb = k[1];
            host.frame(fb ? {8'h42, 20'h0, a, mem[a], 16'h0} : {8'h42, 12'h0, a, mem[a], 24'h0},
                fb ? 48 : 40, 1'b0, 0, rx);
            check(busy, 1'b1);
            wait_idle;
            host.frame({8'h42, 12'h001, a, ~mem[a], 24'h0}, 40, 1'b0, 0, rx);
            check(busy, 1'b0);
            host.frame(fb ? {8'h48, 20'h0, a, 24'h0} : {8'h48, 12'h0, a, 32'h0}, fb ? 48 : 40, 1'b0, 8, rx);
            check(rx[7:0], mem[a]);
        end
        fb = 1'b0;
        host.frame({8'h48, 24'h000FFF, 32'h0}, 40, 1'b0, 16, rx);
        check(rx, exp16(12'hFFF));
        for (int k = 0; k < 7; k++) begin
            @(posedge clk) #1 {wl, sl, sus, dpd} = k < 6 ? bad[k] : 5'h10;
            host.frame({8'h44, 12'h0, 12'($random(seed)), 32'h0}, k == 5 ? 33 : 32, 1'b0, 0, rx);
            check(busy, k == 6);
        end
        wait_idle;
        host.frame({8'h48, 24'h000FFF, 32'h0}, 40, 1'b0, 8, rx);
        check(rx[7:0], 8'hFF);
        $display("security area tests done");
        qa = {8'h0, 24'($random(seed))};
        host.frame({8'h36, qa[23:0], 32'h0}, 32, 1'b0, 0, rx);
        check(qlk, 1'b1);
        host.frame({8'h3D, qa[23:0], 32'h0}, 32, 1'b0, 8, rx);
        check(rx, 16'h0001);
        #1 pss = 1'b1;
        #1 check(qlk, 1'b0);
        pss = 1'b0;
        host.frame({8'h39, qa[23:0], 32'h0}, 32, 1'b0, 0, rx);
        check(qlk, 1'b0);
        for (int k = 0; k < 2; k++) begin
            host.frame({k ? 8'h98 : 8'h7E, 56'h0}, 8, 1'b0, 0, rx);
            check(qlk, !k);
        end
        $display("lock tests done");
        @(posedge clk) #1 fl = 1'b1;
        check(busy, 1'b0);
        host.frame(64'hFFFFFFFFFFFFFFFF, 8, 1'b1, 0, rx);
        host.frame({8'h66, 56'h0}, 2, 1'b1, 0, rx);
        host.frame({8'h99, 56'h0}, 2, 1'b1, 0, rx);
        check(rip, 1'b1);
        host.frame({8'h7E, 56'h0}, 2, 1'b1, 0, rx);
        check(qlk, 1'b0);
        repeat (600) @(posedge clk);
        #1 fl = 1'b0;
        host.frame({8'h66, 56'h0}, 8, 1'b0, 0, rx);
        host.frame({8'h99, 56'h0}, 8, 1'b0, 0, rx);
        check(rip, 1'b1);
        $display("reset tests done");
        finish_test;
    end
endmodule
`default_nettype wire
